// *** verilog/dpsc_pkg.sv ***
package dpsc_pkg;
  localparam int CLK_HZ          = 100_000_000;
  localparam int RESUME_WAIT_MS  = 200;
  localparam int RESUME_WAIT_CYC = RESUME_WAIT_MS * (CLK_HZ / 1000);
  localparam int VSYNC_SLEEP_CNT = 2;
  localparam int IDLE_UNIT_CYC   = 1024;
  localparam int PANEL_STEP_CYC  = 4096;
  localparam int PANEL_LVL_ON    = 4;

  // device configuration port indices and register reset value
  localparam logic [2:0] CFG_POWER_MODE  = 3'h0;
  localparam logic [2:0] CFG_BLOCK_DIS   = 3'h1;
  localparam logic [2:0] CFG_PANEL_PWR   = 3'h2;
  localparam logic [2:0] CFG_IDLE_DET    = 3'h3;
  localparam logic [2:0] CFG_REFCLK_SEL  = 3'h4;
  localparam logic [2:0] CFG_PANEL_SEQ   = 3'h5;
  localparam logic [2:0] CFG_PANEL_TIME  = 3'h6;
  localparam logic [2:0] CFG_STATUS      = 3'h7;
  localparam logic [7:0] CFG_RESET       = 8'h00;

  // field positions
  localparam int PM_SLEEP_SEL = 7;
  localparam int PM_SELF_REF  = 6;
  localparam int PM_CLK_LSB   = 4;
  localparam int RCS_BIT      = 3;
  localparam int PSS_BIT      = 7;
  localparam int PTS_LSB      = 2;
  localparam int IDC_AUTO_LSB = 6;
  localparam int IDC_SEL_LSB  = 0;
  localparam logic [7:0] STBY_BLOCK_MASK = 8'hbe;

  // controller registers on ahb-lite
  localparam logic [7:0] HOST_CTRL_OFF = 8'h00;
  localparam logic [7:0] HOST_STAT_OFF = 8'h04;
  localparam int CTRL_DOWN   = 0;
  localparam int CTRL_AUTO   = 1;
  localparam int CTRL_RESUME = 2;
  localparam int STAT_ACT    = 0;
  localparam int STAT_SEEN   = 1;
  localparam int STAT_PDN    = 2;
  localparam int STAT_PLL    = 3;
  localparam int STAT_BUSY   = 4;
  localparam int STAT_PANEL  = 5;

  typedef struct packed {
    logic [9:0] addr;
    logic       we_n;
    logic [7:0] dqm_n;
    logic       bank;
    logic       rom_enable_n;
    logic       ras_n;
    logic       cas_n;
    logic [1:0] cs_n;
    logic       cke;
  } dpsc_mem_t;

  typedef struct packed {
    logic [23:0] fp_data;
    logic        fp_clk;
    logic        fp_hsync;
    logic        fp_vsync;
    logic        crt_hsync;
    logic        crt_vsync;
  } dpsc_disp_t;
endpackage

// *** verilog/dpsc_link_if.sv ***
`timescale 1ns/1ps
interface dpsc_link_if;
  logic power_down_n;
  logic pll_wake;
  logic activity;
  logic pll_on;
  modport dev (input power_down_n, input pll_wake,
               output activity, output pll_on);
  modport pmu (output power_down_n, output pll_wake,
               input activity, input pll_on);
endinterface

// *** verilog/dpsc_device.sv ***
`timescale 1ns/1ps
// Contract
// R1: standby lowers memory, video clock rates
// R2: standby keeps dram refresh running
// R3: standby gates blocks 7,5,4,3,2,1
// R4: standby powers panel off, dpms standby
// R5: software selects sleep before power-down
// R6: mode bit 6 picks self-refresh or cbr
// R7: external refresh clock lets plls stop
// R8: software panel mode drives panel bits
// R9: hardware panel mode sequences panel power
// R10: two vsyncs after power-down enter sleep
// R11: system waits 200 ms around resume
// R12: software re-enables panel after resume; code drives panel_o again from pp_reg or the sequencer as soon as sleep ends
// R13: idle timer match toggles activity
// R14: access clears activity and idle counter
// R15: idle match enters auto-standby when enabled
// R16: pmu may pull power-down after activity
// R17: sleep tri-states host bus outputs
// R18: sleep parks memory pins at fixed levels
// R19: cbr strobes follow 32 khz clock
// R20: memory data lines keep pull-ups
// R21: sleep parks panel, crt, video, gpio pins
// R22: system standby overrides auto-standby
module dpsc_device #(
  parameter int IDLE_UNIT = dpsc_pkg::IDLE_UNIT_CYC,
  parameter int PANEL_STEP = dpsc_pkg::PANEL_STEP_CYC
) (
  input  wire logic                clock_i,
  input  wire logic                sys_rst_i,
  input  wire logic                ce_i,
  dpsc_link_if.dev                 link,
  input  wire logic                cfg_we_i,
  input  wire logic [2:0]          cfg_addr_i,
  input  wire logic [7:0]          cfg_wdata_i,
  output logic      [7:0]          cfg_rdata_o,
  input  wire logic                access_i,
  input  wire logic                vsync_i,
  input  wire logic                refclk32_i,
  input  wire logic                bus_oe_i,
  input  wire dpsc_pkg::dpsc_mem_t  mem_i,
  input  wire dpsc_pkg::dpsc_disp_t disp_i,
  input  wire logic [3:0]          vport_i,
  input  wire logic [3:0]          gpio_i,
  output logic      [1:0]          clk_rate_o,
  output logic      [7:0]          blocks_off_o,
  output logic                     dram_refresh_o,
  output logic                     screen_refresh_o,
  output logic                     pd_refresh_o,
  output logic                     dpms_standby_o,
  output logic                     refclk_ext_o,
  output logic      [3:0]          panel_o,
  output logic                     host_bus_oe_o,
  output dpsc_pkg::dpsc_mem_t       mem_o,
  output logic                     mem_pullup_o,
  output dpsc_pkg::dpsc_disp_t      disp_o,
  output logic      [3:0]          vport_o,
  output logic      [3:0]          gpio_o
);
  import dpsc_pkg::*;
  typedef enum logic [1:0] {
    ST_ACTIVE, ST_STANDBY, ST_SLEEP_WAIT, ST_SLEEP
  } dpsc_state_t;
  dpsc_state_t state_reg;
  logic [7:0]  pm_reg, bd_reg, pp_reg, id_reg;
  logic [7:0]  rcs_reg, pss_reg, pts_reg;
  logic        sys_reg;
  logic [1:0]  vcnt_reg;
  logic        vs_prev_reg, ref_prev_reg;
  logic [31:0] idle_cnt_reg, pan_tmr_reg;
  logic        idle_hit_reg, act_reg;
  logic [2:0]  pan_lvl_reg;
  logic [31:0] idle_period, pan_period;
  logic        idle_fire, auto_ok, vs_rise, ref_tick;
  logic        pdn, sleep, lowp;
  logic [2:0]  pan_target;
  // panel power order: supply, enable, bias, backlight
  function automatic logic [3:0] pan_map(input logic [2:0] lvl);
    pan_map = {lvl >= 3'd4, lvl >= 3'd3, lvl >= 3'd2, lvl >= 3'd1};
    pan_map = {pan_map[3], pan_map[2], pan_map[0], pan_map[1]};
  endfunction
  assign pdn         = link.power_down_n;
  assign sleep       = (state_reg == ST_SLEEP);
  assign lowp        = sleep || (state_reg == ST_STANDBY);
  assign vs_rise     = vsync_i & ~vs_prev_reg;
  assign ref_tick    = refclk32_i & ~ref_prev_reg;
  assign idle_period = 32'(IDLE_UNIT) << id_reg[IDC_SEL_LSB +: 3];
  assign idle_fire   = ~access_i & ~idle_hit_reg &
                       (idle_cnt_reg >= idle_period - 32'd1);
  assign auto_ok     = idle_fire && (id_reg[IDC_AUTO_LSB +: 2] == 2'b11)
                       && !pm_reg[PM_SLEEP_SEL]; // [R15]
  assign pan_period  = 32'(PANEL_STEP) << pts_reg[PTS_LSB +: 2];
  assign pan_target  = lowp ? 3'd0 : 3'(PANEL_LVL_ON); // [R4]
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pm_reg  <= CFG_RESET;
      bd_reg  <= CFG_RESET;
      pp_reg  <= CFG_RESET;
      id_reg  <= CFG_RESET;
      rcs_reg <= CFG_RESET;
      pss_reg <= CFG_RESET;
      pts_reg <= CFG_RESET;
    end else if (ce_i && cfg_we_i) begin
      if (cfg_addr_i == CFG_POWER_MODE) pm_reg <= cfg_wdata_i;
      else if (cfg_addr_i == CFG_BLOCK_DIS) bd_reg <= cfg_wdata_i;
      else if (cfg_addr_i == CFG_PANEL_PWR) pp_reg <= cfg_wdata_i;
      else if (cfg_addr_i == CFG_IDLE_DET) id_reg <= cfg_wdata_i;
      else if (cfg_addr_i == CFG_REFCLK_SEL) rcs_reg <= cfg_wdata_i;
      else if (cfg_addr_i == CFG_PANEL_SEQ) pss_reg <= cfg_wdata_i;
      else if (cfg_addr_i == CFG_PANEL_TIME) pts_reg <= cfg_wdata_i;
    end
  end
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cfg_rdata_o <= 8'h00;
    end else if (ce_i) begin
      if (cfg_addr_i == CFG_POWER_MODE) cfg_rdata_o <= pm_reg;
      else if (cfg_addr_i == CFG_BLOCK_DIS) cfg_rdata_o <= bd_reg;
      else if (cfg_addr_i == CFG_PANEL_PWR) cfg_rdata_o <= pp_reg;
      else if (cfg_addr_i == CFG_IDLE_DET) cfg_rdata_o <= id_reg;
      else if (cfg_addr_i == CFG_REFCLK_SEL) cfg_rdata_o <= rcs_reg;
      else if (cfg_addr_i == CFG_PANEL_SEQ) cfg_rdata_o <= pss_reg;
      else if (cfg_addr_i == CFG_PANEL_TIME) cfg_rdata_o <= pts_reg;
      else cfg_rdata_o <= {pan_lvl_reg, act_reg, idle_hit_reg, sys_reg,
                           2'(state_reg)};
    end
  end
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      vs_prev_reg  <= 1'b0;
      ref_prev_reg <= 1'b0;
    end else if (ce_i) begin
      vs_prev_reg  <= vsync_i;
      ref_prev_reg <= refclk32_i;
    end
  end
  // idle timer stops after one match until the next access
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      idle_cnt_reg <= 32'd0;
      idle_hit_reg <= 1'b0;
      act_reg      <= 1'b0;
    end else if (ce_i) begin
      if (access_i) begin
        idle_cnt_reg <= 32'd0; // [R14]
        idle_hit_reg <= 1'b0;
        act_reg      <= 1'b0; // [R14]
      end else if (idle_fire) begin
        idle_hit_reg <= 1'b1;
        act_reg      <= ~act_reg; // [R13]
      end else if (!idle_hit_reg) begin
        idle_cnt_reg <= idle_cnt_reg + 32'd1; // [R13]
      end
    end
  end
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_ACTIVE;
      sys_reg   <= 1'b0;
      vcnt_reg  <= 2'd0;
    end else if (ce_i) begin
      case (state_reg)
        ST_ACTIVE: begin
          vcnt_reg <= 2'd0;
          if (!pdn) begin
            sys_reg   <= 1'b1;
            state_reg <= pm_reg[PM_SLEEP_SEL] ? ST_SLEEP_WAIT
                                              : ST_STANDBY; // [R5]
          end else if (auto_ok) begin
            sys_reg   <= 1'b0;
            state_reg <= ST_STANDBY; // [R15]
          end
        end
        ST_STANDBY: begin
          if (sys_reg && pdn) state_reg <= ST_ACTIVE; // [R22]
          else if (!sys_reg && !pdn) begin
            sys_reg <= 1'b1; // [R22]
            if (pm_reg[PM_SLEEP_SEL]) state_reg <= ST_SLEEP_WAIT;
          end else if (!sys_reg && access_i) state_reg <= ST_ACTIVE;
        end
        ST_SLEEP_WAIT: begin
          if (pdn) state_reg <= ST_ACTIVE;
          else if (vs_rise) begin
            vcnt_reg <= vcnt_reg + 2'd1;
            if (vcnt_reg == 2'(VSYNC_SLEEP_CNT - 1))
              state_reg <= ST_SLEEP; // [R10]
          end
        end
        ST_SLEEP: if (pdn) state_reg <= ST_ACTIVE;
        default: state_reg <= ST_ACTIVE;
      endcase
    end
  end
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pan_lvl_reg <= 3'd0;
      pan_tmr_reg <= 32'd0;
    end else if (ce_i) begin
      if (pan_lvl_reg == pan_target) begin
        pan_tmr_reg <= 32'd0;
      end else if (pan_tmr_reg == pan_period - 32'd1) begin
        pan_tmr_reg <= 32'd0;
        pan_lvl_reg <= (pan_lvl_reg < pan_target) ? pan_lvl_reg + 3'd1
                                                  : pan_lvl_reg - 3'd1; // [R9]
      end else begin
        pan_tmr_reg <= pan_tmr_reg + 32'd1;
      end
    end
  end
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      clk_rate_o       <= 2'b00;
      blocks_off_o     <= 8'h00;
      dram_refresh_o   <= 1'b1;
      screen_refresh_o <= 1'b1;
      pd_refresh_o     <= 1'b0;
      dpms_standby_o   <= 1'b0;
      refclk_ext_o     <= 1'b1;
      panel_o          <= 4'h0;
      link.activity    <= 1'b0;
      link.pll_on      <= 1'b1;
    end else if (ce_i) begin
      clk_rate_o <= (state_reg == ST_STANDBY) ?
                    pm_reg[PM_CLK_LSB +: 2] : 2'b00; // [R1]
      blocks_off_o <= bd_reg | (lowp ? STBY_BLOCK_MASK : 8'h00); // [R3]
      dram_refresh_o   <= ~sleep; // [R2]
      screen_refresh_o <= ~sleep; // [R10]
      pd_refresh_o     <= sleep; // [R10]
      dpms_standby_o   <= (state_reg == ST_STANDBY); // [R4]
      refclk_ext_o     <= ~rcs_reg[RCS_BIT]; // [R7]
      if (sleep) panel_o <= 4'h0;
      else if (pss_reg[PSS_BIT]) panel_o <= pan_map(pan_lvl_reg); // [R9]
      else if (lowp) panel_o <= 4'h0; // [R4]
      else panel_o <= pp_reg[3:0]; // [R8]
      link.activity <= act_reg; // [R13]
      link.pll_on   <= ~(sleep && (!rcs_reg[RCS_BIT] ||
                       pm_reg[PM_SELF_REF])) || link.pll_wake; // [R7]
    end
  end
  // pins parked in sleep; core values pass through otherwise
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      host_bus_oe_o <= 1'b0;
      mem_o         <= '1;
      mem_pullup_o  <= 1'b1;
      disp_o        <= '0;
      vport_o       <= 4'hf;
      gpio_o        <= 4'hf;
    end else if (ce_i) begin
      host_bus_oe_o <= bus_oe_i & ~sleep; // [R17]
      mem_pullup_o  <= 1'b1; // [R20]
      if (sleep) begin
        mem_o              <= '1; // [R18]
        mem_o.cs_n         <= 2'b00; // [R18]
        mem_o.cke          <= ~pm_reg[PM_SELF_REF]; // [R6]
        mem_o.ras_n        <= pm_reg[PM_SELF_REF] ? 1'b0 : ~ref_tick; // [R19]
        mem_o.cas_n        <= pm_reg[PM_SELF_REF] ? 1'b0 : ~ref_tick; // [R19]
        disp_o             <= '0; // [R21]
        vport_o            <= 4'hf; // [R21]
        gpio_o             <= 4'hf; // [R21]
      end else begin
        mem_o   <= mem_i;
        disp_o  <= disp_i;
        vport_o <= vport_i;
        gpio_o  <= gpio_i;
      end
    end
  end
endmodule // dpsc_device

// *** verilog/dpsc_host.sv ***
`timescale 1ns/1ps
module dpsc_host #(
  parameter int RESUME_CYC = dpsc_pkg::RESUME_WAIT_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ce_i,
  dpsc_link_if.pmu         link,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o
);
  import dpsc_pkg::*;

  typedef enum logic [1:0] {
    HS_IDLE, HS_WAIT_PLL, HS_WAIT_UP, HS_WAIT_PANEL
  } dpsc_hstate_t;

  dpsc_hstate_t hs_reg;
  logic [31:0]  tmr_reg;
  logic         down_reg, auto_reg, seen_reg, panel_ok_reg, act_prev_reg;
  logic         wr_pend_reg;
  logic [7:0]   wr_addr_reg;
  logic         addr_ok, wr_ctrl, wr_stat, act_edge, resume_go;

  assign addr_ok   = hsel_i && hready_i && htrans_i[1];
  assign wr_ctrl   = wr_pend_reg && (wr_addr_reg == HOST_CTRL_OFF);
  assign wr_stat   = wr_pend_reg && (wr_addr_reg == HOST_STAT_OFF);
  assign act_edge  = link.activity ^ act_prev_reg;
  assign resume_go = wr_ctrl && hwdata_i[CTRL_RESUME] && hs_reg == HS_IDLE;

  // zero-wait slave: read data is latched in the address phase
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_o    <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else if (ce_i) begin
      wr_pend_reg <= addr_ok && hwrite_i;
      wr_addr_reg <= haddr_i[7:0];
      if (addr_ok && !hwrite_i) begin
        if (haddr_i[7:0] == HOST_CTRL_OFF)
          hrdata_o <= {30'h0, auto_reg, down_reg};
        else if (haddr_i[7:0] == HOST_STAT_OFF)
          hrdata_o <= {26'h0, panel_ok_reg, hs_reg != HS_IDLE,
                       link.pll_on, link.power_down_n, seen_reg,
                       link.activity};
        else
          hrdata_o <= 32'h0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      act_prev_reg <= 1'b0;
      seen_reg     <= 1'b0;
      auto_reg     <= 1'b0;
    end else if (ce_i) begin
      act_prev_reg <= link.activity;
      if (wr_ctrl) auto_reg <= hwdata_i[CTRL_AUTO];
      // a new edge wins over a write-one clear
      if (act_edge) seen_reg <= 1'b1;
      else if (wr_stat && hwdata_i[STAT_SEEN]) seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      hs_reg            <= HS_IDLE;
      tmr_reg           <= 32'd0;
      down_reg          <= 1'b0;
      panel_ok_reg      <= 1'b1;
      link.power_down_n <= 1'b1;
      link.pll_wake     <= 1'b0;
    end else if (ce_i) begin
      link.power_down_n <= ~down_reg;
      case (hs_reg)
        HS_IDLE: begin
          tmr_reg <= 32'd0;
          if (resume_go && down_reg) begin
            link.pll_wake <= 1'b1;
            hs_reg        <= HS_WAIT_PLL;
          end else if (wr_ctrl && hwdata_i[CTRL_DOWN]) begin
            down_reg      <= 1'b1;
            panel_ok_reg  <= 1'b0;
            link.pll_wake <= 1'b0;
          end else if (wr_ctrl) begin
            down_reg <= 1'b0;
          end else if (auto_reg && act_edge && link.activity) begin
            down_reg      <= 1'b1; // [R16]
            panel_ok_reg  <= 1'b0;
            link.pll_wake <= 1'b0;
          end
        end
        HS_WAIT_PLL: begin
          if (link.pll_on) hs_reg <= HS_WAIT_UP;
        end
        HS_WAIT_UP: begin
          tmr_reg <= tmr_reg + 32'd1;
          if (tmr_reg == 32'(RESUME_CYC - 1)) begin
            down_reg <= 1'b0; // [R11]
            tmr_reg  <= 32'd0;
            hs_reg   <= HS_WAIT_PANEL;
          end
        end
        HS_WAIT_PANEL: begin
          tmr_reg <= tmr_reg + 32'd1;
          if (tmr_reg == 32'(RESUME_CYC - 1)) begin
            panel_ok_reg <= 1'b1; // [R11]
            hs_reg       <= HS_IDLE;
          end
        end
        default: hs_reg <= HS_IDLE;
      endcase
    end
  end
endmodule // dpsc_host

// *** verification/dpsc_link_sva.sv ***
`timescale 1ns/1ps
module dpsc_link_sva #(
  parameter int RESUME_CYC = 50,
  parameter int IDLE_UNIT  = 4
) (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic power_down_n,
  input  wire logic pll_wake,
  input  wire logic activity,
  input  wire logic pll_on
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  int   pll_cnt;
  int   quiet;
  logic act_q;

  // saturating run length of pll_on, so resume timing is judged
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !pll_on) pll_cnt <= 0;
    else if (pll_cnt < RESUME_CYC) pll_cnt <= pll_cnt + 1;
  end

  always_ff @(posedge clock_i) begin
    act_q <= activity;
    if (sys_rst_i || activity != act_q) quiet <= 0;
    else if (quiet < 4096) quiet <= quiet + 1;
  end

  sequence s_plls_up;
    ##[0:3] pll_on ##1 pll_on;
  endsequence

  a_wake_plls_on: assert property (pll_wake |-> s_plls_up)
    else $error("pll did not start on wake");
  a_pll_off_sleep: assert property ($fell(pll_on) |->
    !power_down_n && !pll_wake) else $error("pll stopped outside sleep");
  a_pll_off_late: assert property ($fell(pll_on) |->
    $past(power_down_n) == 1'b0 && $past(power_down_n, 2) == 1'b0)
    else $error("pll stopped before sleep entry");
  a_pll_low_down: assert property (!pll_on |-> !power_down_n)
    else $error("power-down released with pll off");
  a_resume_wait: assert property ($rose(power_down_n) |->
    pll_cnt >= RESUME_CYC - 1) else $error("resume came too early");
  a_wake_down_only: assert property ($rose(pll_wake) |->
    !power_down_n) else $error("wake raised while running");
  a_wake_release: assert property ($fell(pll_wake) |->
    power_down_n) else $error("wake dropped while still down");
  a_idle_rise_gap: assert property ($rose(activity) |->
    quiet >= IDLE_UNIT - 2) else $error("activity toggled too soon");
endmodule // dpsc_link_sva

// *** verification/display_power_sleep_ctrl_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, e) chk(32'(a), 32'(e))
`define WAIT(c) while (!(c)) @(negedge clock_i)
module display_power_sleep_ctrl_tb;
  import dpsc_pkg::*;
  localparam int RC = 50;
  localparam int IU = 4;
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        bus_oe_i = 1'b1;
  logic        cfg_we_i = 1'b0;
  logic [2:0]  cfg_addr_i = 3'h0;
  logic [7:0]  cfg_wdata_i = 8'h00;
  logic        access_i = 1'b0, vsync_i = 1'b0, refclk32_i = 1'b0;
  dpsc_mem_t   mem_i = '0, mem_o;
  dpsc_disp_t  disp_i = '0, disp_o;
  logic [3:0]  vport_i = 4'h0, gpio_i = 4'h0, vport_o, gpio_o, panel_o;
  logic        hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [31:0] haddr_i = '0, hwdata_i = '0, hrdata_o, r;
  logic [1:0]  htrans_i = 2'h0;
  logic [2:0]  hsize_i = 3'h2;
  logic        hready_i, hreadyout_o, hresp_o;
  logic [7:0]  cfg_rdata_o, blocks_off_o, b;
  logic [1:0]  clk_rate_o, rate;
  logic        dram_refresh_o, screen_refresh_o, pd_refresh_o;
  logic        dpms_standby_o, refclk_ext_o, host_bus_oe_o, mem_pullup_o;
  int          bad_count = 0, n_checks = 0, cyc = 0, n, t0, sel;
  int          cfg_m[8];

  assign hready_i = hreadyout_o;
  dpsc_link_if lnk ();
  dpsc_device #(.IDLE_UNIT(IU), .PANEL_STEP(2)) i_dpsc_device (
    .clock_i, .sys_rst_i, .ce_i, .link(lnk), .cfg_we_i, .cfg_addr_i,
    .cfg_wdata_i, .cfg_rdata_o, .access_i, .vsync_i, .refclk32_i, .bus_oe_i,
    .mem_i, .disp_i, .vport_i, .gpio_i, .clk_rate_o, .blocks_off_o,
    .dram_refresh_o, .screen_refresh_o, .pd_refresh_o, .dpms_standby_o,
    .refclk_ext_o, .panel_o, .host_bus_oe_o, .mem_o, .mem_pullup_o, .disp_o,
    .vport_o, .gpio_o);
  dpsc_host #(.RESUME_CYC(RC)) i_dpsc_host (
    .clock_i, .sys_rst_i, .ce_i, .link(lnk), .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o,
    .hresp_o);
  dpsc_link_sva #(.RESUME_CYC(RC), .IDLE_UNIT(IU)) i_dpsc_link_sva (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .power_down_n(lnk.power_down_n), .pll_wake(lnk.pll_wake),
    .activity(lnk.activity), .pll_on(lnk.pll_on));

  initial begin
    forever #5 clock_i = ~clock_i;
  end

  // core pin values churn so parked outputs cannot just echo them
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    mem_i <= $bits(mem_i)'($urandom);
    disp_i <= $bits(disp_i)'($urandom);
    vport_i <= 4'($urandom);
    gpio_i <= 4'($urandom);
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    n_checks++;
    if (a !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, a, e);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    do @(posedge clock_i); while (hready_i !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clock_i); while (hready_i !== 1'b1);
    r = hrdata_o;
  endtask

  task automatic cfg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    cfg_we_i <= 1'b1;
    cfg_addr_i <= a;
    cfg_wdata_i <= d;
    cfg_m[a] = int'(d);
    @(posedge clock_i);
    cfg_we_i <= 1'b0;
  endtask

  // 0 access, 1 vsync, 2 refresh clock tick
  task automatic pulse(input int k);
    @(posedge clock_i);
    case (k)
      0: access_i <= 1'b1;
      1: vsync_i <= 1'b1;
      default: refclk32_i <= 1'b1;
    endcase
    @(posedge clock_i);
    access_i <= 1'b0;
    vsync_i <= 1'b0;
    refclk32_i <= 1'b0;
  endtask

  initial begin
    void'($urandom(32'h7efb));
    repeat (12) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(negedge clock_i);
    `CHK({clk_rate_o, blocks_off_o, pd_refresh_o, dpms_standby_o}, 12'h0);
    `CHK({dram_refresh_o, refclk_ext_o, mem_pullup_o}, 3'h7);
    for (int i = 0; i < 7; i++) cfg_wr(3'(i), 8'($urandom));
    for (int i = 0; i < 7; i++) begin
      @(posedge clock_i);
      cfg_addr_i <= 3'(i);
      @(posedge clock_i);
      @(negedge clock_i);
      `CHK(cfg_rdata_o, cfg_m[i][7:0]);
      cfg_wr(3'(i), 8'h00);
    end
    ahb(1'b0, HOST_STAT_OFF, 32'h0);
    `CHK(r & 32'hc, 32'hc);
    `CHK({hreadyout_o, hresp_o}, 2'b10);
    ahb(1'b0, 8'h08, 32'h0);
    `CHK(r, 32'h0);
    b = 8'($urandom);
    cfg_wr(CFG_PANEL_PWR, {4'h0, b[3:0]});
    repeat (3) @(negedge clock_i);
    `CHK(panel_o, b[3:0]);
    rate = 2'($urandom | 1);
    cfg_wr(CFG_POWER_MODE, {2'b00, rate, 4'h0});
    cfg_wr(CFG_BLOCK_DIS, b);
    cfg_wr(CFG_IDLE_DET, 8'hc0);
    ahb(1'b1, HOST_CTRL_OFF, 32'h1);
    `WAIT(dpms_standby_o === 1'b1);
    @(negedge clock_i);
    `CHK(clk_rate_o, rate);
    `CHK(blocks_off_o, b | STBY_BLOCK_MASK);
    `CHK({dram_refresh_o, panel_o}, 5'h10);
    @(posedge clock_i);
    cfg_addr_i <= CFG_STATUS;
    repeat (2) @(negedge clock_i);
    `CHK(cfg_rdata_o[2:0], 3'h5);
    pulse(0);
    repeat (3) @(negedge clock_i);
    `CHK(dpms_standby_o, 1'b1);
    ahb(1'b1, HOST_CTRL_OFF, 32'h0);
    `WAIT(dpms_standby_o === 1'b0);
    @(negedge clock_i);
    `CHK({clk_rate_o, panel_o}, {2'b00, b[3:0]});
    sel = $urandom % 4;
    cfg_wr(CFG_IDLE_DET, 8'(8'hc0 | sel));
    pulse(0);
    `WAIT(lnk.activity === 1'b0);
    n = 0;
    while (lnk.activity !== 1'b1) begin
      @(negedge clock_i);
      n++;
    end
    `CHK(n >= (IU << sel) - 2 && n <= (IU << sel) + 2, 1'b1);
    `WAIT(dpms_standby_o === 1'b1);
    `CHK(clk_rate_o, rate);
    ahb(1'b0, HOST_STAT_OFF, 32'h0);
    `CHK(r[STAT_ACT], 1'b1);
    pulse(0);
    `WAIT(dpms_standby_o === 1'b0);
    `CHK(lnk.activity, 1'b0);
    cfg_wr(CFG_IDLE_DET, 8'h07);
    cfg_wr(CFG_BLOCK_DIS, 8'h00);
    for (int sr = 1; sr >= 0; sr--) begin
      cfg_wr(CFG_POWER_MODE, sr ? 8'hc0 : 8'h80);
      cfg_wr(CFG_REFCLK_SEL, sr ? 8'h00 : 8'h08);
      cfg_wr(CFG_PANEL_SEQ, 8'h80);
      `WAIT(panel_o === 4'hf);
      `CHK(refclk_ext_o, sr != 0);
      ahb(1'b1, HOST_CTRL_OFF, 32'h1);
      `WAIT(lnk.power_down_n === 1'b0);
      pulse(1);
      pulse(1);
      `WAIT(pd_refresh_o === 1'b1);
      @(negedge clock_i);
      `CHK({screen_refresh_o, dram_refresh_o, blocks_off_o}, 10'hbe);
      `CHK(host_bus_oe_o, 1'b0);
      `CHK(mem_o, {10'h3ff, 11'h7ff, ~sr[0], ~sr[0], 2'b00, ~sr[0]});
      `CHK(disp_o, 29'h0);
      `CHK({vport_o, gpio_o, mem_pullup_o}, 9'h1ff);
      `CHK(lnk.pll_on, sr == 0);
      `WAIT(panel_o === 4'h0);
      if (sr == 0) begin
        pulse(2);
        `WAIT(mem_o.ras_n === 1'b0);
        `CHK(mem_o.cas_n, 1'b0);
        @(negedge clock_i);
        `CHK({mem_o.ras_n, mem_o.cas_n}, 2'b11);
      end
      ahb(1'b1, HOST_CTRL_OFF, 32'h5);
      `WAIT(lnk.power_down_n === 1'b1);
      t0 = cyc;
      `WAIT(pd_refresh_o === 1'b0);
      `CHK(screen_refresh_o, 1'b1);
      r = '0;
      while (r[STAT_PANEL] !== 1'b1) ahb(1'b0, HOST_STAT_OFF, 32'h0);
      `CHK(cyc - t0 >= RC, 1'b1);
      ahb(1'b1, HOST_CTRL_OFF, 32'h0);
    end
    summarize();
  end
endmodule // display_power_sleep_ctrl_tb
